// [rtl/dsc_defs.vh]
// constants for the deserializer strap and pin control block
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH
`define DSC_EQ_CODE_W 4
`define DSC_EQ_CODE_STRONG 4'h9
`define DSC_EQ_CODE_WEAK 4'h4
`define DSC_BUS_W 29
`define DSC_NARROW_W 21
`define DSC_STRAP_N 8
`define DSC_S_OE_N 0
`define DSC_S_BWS 1
`define DSC_S_IRQ 2
`define DSC_S_CDIR 3
`define DSC_S_EDGE 4
`define DSC_S_EQ 5
`define DSC_S_MODE 6
`define DSC_S_POWER_DOWN_N 7
`endif

// [rtl/dsc_strap_config.v]
// strap capture, output gating, interrupt toggle and general pin control
`timescale 1ns/1ps
// Overview of operation
// - a low output-enable strap drives clock, audio and data outputs, high sets them to high impedance.
// - the bus-width strap selects 21-bit output when low and 29-bit output when high.
// - every transition of the interrupt input held for at least two clock cycles toggles the interrupt level sent to the serializer.
// - the control-direction strap puts the controller on the serializer side when low, local side when high.
// - the general pins stay released during power-up and while power-down is held low.
// - the edge strap selects rising output-clock edge when low and falling edge when high.
// - the equalizer strap is captured at power-up and each power-down release, low gives 1001, high gives 0100.
// - with direction high the mode strap selects base mode when low and bypass mode when high.
// - with direction low the mode strap selects the autostart behaviour instead.
`include "dsc_defs.vh"
module dsc_strap_config #(
	parameter BUS_W = `DSC_BUS_W
) (
	input wire clock_in,
	input wire rst_in,
	input wire out_enable_n_in,
	input wire bus_width_select_in,
	input wire irq_in,
	input wire ctrl_direction_select_in,
	input wire clock_edge_select_in,
	input wire equalizer_boost_select_in,
	input wire link_mode_select_in,
	input wire power_down_n_in,
	input wire [BUS_W-1:0] data_in,
	input wire general_pin_zero_drive_low_in,
	input wire general_pin_one_drive_low_in,
	output reg [BUS_W-1:0] data_out,
	output reg data_oe_out,
	output reg audio_oe_out,
	output reg parallel_clock_oe_out,
	output reg bus_wide_out,
	output reg clock_falling_edge_out,
	output reg ctrl_local_out,
	output reg ctrl_bypass_out,
	output reg autostart_select_out,
	output reg irq_toggle_out,
	output reg [`DSC_EQ_CODE_W-1:0] equalizer_tuning_code_out,
	output reg general_pin_zero_out,
	output reg general_pin_zero_oe_out,
	output reg general_pin_one_out,
	output reg general_pin_one_oe_out
);

	wire [`DSC_STRAP_N-1:0] raw_w;
	reg [`DSC_STRAP_N-1:0] s1_q;
	reg [`DSC_STRAP_N-1:0] s2_q;
	reg [`DSC_STRAP_N-1:0] s3_q;
	reg [`DSC_STRAP_N-1:0] st_q;
	reg pwr_up_q;
	reg power_down_n_prev_q;
	wire [BUS_W-1:0] narrow_mask_w;
	wire oe_n_w;
	wire wide_w;
	wire cdir_w;
	wire edge_w;
	wire eq_w;
	wire mode_w;
	wire power_down_n_n_w;
	wire irq_accept_w;
	wire eq_capture_w;
	wire pins_allowed_w;
	wire [`DSC_EQ_CODE_W-1:0] eq_code_w;

	assign raw_w = {power_down_n_in, link_mode_select_in, equalizer_boost_select_in, clock_edge_select_in,
		ctrl_direction_select_in, irq_in, bus_width_select_in, out_enable_n_in};

	// accepted strap levels
	assign oe_n_w = st_q[`DSC_S_OE_N];
	assign wide_w = st_q[`DSC_S_BWS];
	assign cdir_w = st_q[`DSC_S_CDIR];
	assign edge_w = st_q[`DSC_S_EDGE];
	assign eq_w = st_q[`DSC_S_EQ];
	assign mode_w = st_q[`DSC_S_MODE];
	assign power_down_n_n_w = st_q[`DSC_S_POWER_DOWN_N];

	// new irq level accepted this edge
	assign irq_accept_w = (s2_q[`DSC_S_IRQ] == s3_q[`DSC_S_IRQ]) && (s3_q[`DSC_S_IRQ] != st_q[`DSC_S_IRQ]);

	assign eq_capture_w = pwr_up_q | (power_down_n_n_w & ~power_down_n_prev_q);
	assign eq_code_w = eq_w ? `DSC_EQ_CODE_WEAK : `DSC_EQ_CODE_STRONG;

	// pins may pull only when powered
	assign pins_allowed_w = ~pwr_up_q & power_down_n_n_w;

	always @(posedge clock_in) begin
		s1_q <= raw_w;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	genvar i;
	generate
		for (i = 0; i < `DSC_STRAP_N; i = i + 1) begin : g_strap
			always @(posedge clock_in) begin
				if (rst_in) begin
					st_q[i] <= (i == `DSC_S_OE_N);
				end else if (s2_q[i] == s3_q[i]) begin
					st_q[i] <= s3_q[i];
				end
			end
		end
	endgenerate

	// bits below 21 pass in both widths
	generate
		for (i = 0; i < BUS_W; i = i + 1) begin : g_mask
			assign narrow_mask_w[i] = (i < `DSC_NARROW_W);
		end
	endgenerate

	// power-up marker, one cycle after reset
	always @(posedge clock_in) begin
		if (rst_in) begin
			pwr_up_q <= 1'b1;
		end else begin
			pwr_up_q <= 1'b0;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			power_down_n_prev_q <= 1'b0;
		end else begin
			power_down_n_prev_q <= power_down_n_n_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			data_oe_out <= 1'b0;
		end else begin
			data_oe_out <= ~oe_n_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			audio_oe_out <= 1'b0;
		end else begin
			audio_oe_out <= ~oe_n_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			parallel_clock_oe_out <= 1'b0;
		end else begin
			parallel_clock_oe_out <= ~oe_n_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			bus_wide_out <= 1'b0;
		end else begin
			bus_wide_out <= wide_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			data_out <= {BUS_W{1'b0}};
		end else if (wide_w) begin
			data_out <= data_in;
		end else begin
			data_out <= data_in & narrow_mask_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			clock_falling_edge_out <= 1'b0;
		end else begin
			clock_falling_edge_out <= edge_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			ctrl_local_out <= 1'b0;
		end else begin
			ctrl_local_out <= cdir_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			ctrl_bypass_out <= 1'b0;
		end else begin
			ctrl_bypass_out <= cdir_w & mode_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			autostart_select_out <= 1'b0;
		end else begin
			autostart_select_out <= ~cdir_w & mode_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			irq_toggle_out <= 1'b0;
		end else if (irq_accept_w) begin
			irq_toggle_out <= ~irq_toggle_out;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			equalizer_tuning_code_out <= `DSC_EQ_CODE_STRONG;
		end else if (eq_capture_w) begin
			equalizer_tuning_code_out <= eq_code_w;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			general_pin_zero_out <= 1'b0;
		end else begin
			general_pin_zero_out <= 1'b0;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			general_pin_zero_oe_out <= 1'b0;
		end else begin
			general_pin_zero_oe_out <= pins_allowed_w & general_pin_zero_drive_low_in;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			general_pin_one_out <= 1'b0;
		end else begin
			general_pin_one_out <= 1'b0;
		end
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			general_pin_one_oe_out <= 1'b0;
		end else begin
			general_pin_one_oe_out <= pins_allowed_w & general_pin_one_drive_low_in;
		end
	end

endmodule // dsc_strap_config

// [testbench/dsc_ser_model.sv]
// serializer side interrupt toggle counter
`timescale 1ns/1ps
module dsc_ser_model(input wire logic clock_in, input wire logic level_in, output int count_out = 0);
	logic seen_q = 0;
	always @(posedge clock_in) begin
		seen_q <= level_in;
		if (level_in !== seen_q) count_out <= count_out + 1;
	end
endmodule // dsc_ser_model

// [testbench/dsc_props.sv]
// port assertions for the strap block
`timescale 1ns/1ps
module dsc_props(input wire clock_in, rst_in, out_enable_n_in, data_oe_out, irq_in, irq_toggle_out,
	input wire power_down_n_in, general_pin_one_oe_out, bus_width_select_in, bus_wide_out, equalizer_boost_select_in,
	input wire [3:0] equalizer_tuning_code_out);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	chk_oe_on: assert property ($fell(out_enable_n_in) |-> ##[2:7] data_oe_out) else $error("on");
	chk_oe_off: assert property ($rose(out_enable_n_in) |-> ##[2:7] !data_oe_out) else $error("off");
	chk_bus_wide: assert property ($rose(bus_width_select_in) |-> ##[2:7] bus_wide_out) else $error("bw");
	chk_irq_flip: assert property ($changed(irq_in) |-> ##[2:6] $changed(irq_toggle_out)) else $error("irq");
	chk_irq_quiet: assert property ($stable(irq_in)[*8] |-> $stable(irq_toggle_out)) else $error("irq");
	chk_pin_off: assert property (!power_down_n_in && !$past(power_down_n_in, 7) |-> !general_pin_one_oe_out)
		else $error("pin");
	chk_eq_load: assert property ($rose(power_down_n_in) |-> ##[4:9]
		equalizer_tuning_code_out == (equalizer_boost_select_in ? 4'h4 : 4'h9)) else $error("eq");
	chk_eq_hold: assert property ($stable(power_down_n_in)[*8] |-> $stable(equalizer_tuning_code_out)) else $error("eq");
endmodule // dsc_props

// [testbench/dsc_tb.sv]
// stimulus and checks for the strap block
`timescale 1ns/1ps
module tb;
	logic clock_in = 0, rst_in = 1, out_enable_n_in = 1, bus_width_select_in = 0, irq_in = 0, power_down_n_in = 1;
	logic ctrl_direction_select_in = 0, clock_edge_select_in = 0, equalizer_boost_select_in = 0, link_mode_select_in = 0;
	logic general_pin_zero_drive_low_in = 0, general_pin_one_drive_low_in = 0, data_oe_out, audio_oe_out, bus_wide_out;
	logic parallel_clock_oe_out, clock_falling_edge_out, ctrl_local_out, ctrl_bypass_out, autostart_select_out;
	logic irq_toggle_out, general_pin_zero_out, general_pin_zero_oe_out, general_pin_one_out, general_pin_one_oe_out;
	logic [28:0] data_in = 29'h1fffffff, data_out;
	logic [3:0] equalizer_tuning_code_out;
	int n_errors = 0, samples_checked = 0, n, b;
	dsc_strap_config i_dut(.clock_in(clock_in), .rst_in(rst_in), .out_enable_n_in(out_enable_n_in),
		.bus_width_select_in(bus_width_select_in), .irq_in(irq_in), .ctrl_direction_select_in(ctrl_direction_select_in),
		.clock_edge_select_in(clock_edge_select_in), .equalizer_boost_select_in(equalizer_boost_select_in),
		.link_mode_select_in(link_mode_select_in), .power_down_n_in(power_down_n_in), .data_in(data_in),
		.general_pin_zero_drive_low_in(general_pin_zero_drive_low_in),
		.general_pin_one_drive_low_in(general_pin_one_drive_low_in), .data_out(data_out), .data_oe_out(data_oe_out),
		.audio_oe_out(audio_oe_out), .parallel_clock_oe_out(parallel_clock_oe_out), .bus_wide_out(bus_wide_out),
		.clock_falling_edge_out(clock_falling_edge_out), .ctrl_local_out(ctrl_local_out),
		.ctrl_bypass_out(ctrl_bypass_out), .autostart_select_out(autostart_select_out),
		.irq_toggle_out(irq_toggle_out), .equalizer_tuning_code_out(equalizer_tuning_code_out),
		.general_pin_zero_out(general_pin_zero_out), .general_pin_zero_oe_out(general_pin_zero_oe_out),
		.general_pin_one_out(general_pin_one_out), .general_pin_one_oe_out(general_pin_one_oe_out));
	dsc_ser_model i_ser(.clock_in(clock_in), .level_in(irq_toggle_out), .count_out(n));
	always #5 clock_in = !clock_in;
	task go(input int k);
		repeat (k) @(negedge clock_in);
	endtask
	task cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#9000 n_errors++;
		wrap_up;
	end
	initial begin
		repeat (20) @(posedge clock_in);
		rst_in <= 0;
		go(8);
		cmp("eq", 4'h9, equalizer_tuning_code_out);
		cmp("narrow", 29'h1fffff, data_out);
		cmp("idle", 0, {data_oe_out, audio_oe_out, parallel_clock_oe_out, bus_wide_out, clock_falling_edge_out});
		@(posedge clock_in) out_enable_n_in <= 0;
		{bus_width_select_in, clock_edge_select_in, ctrl_direction_select_in, link_mode_select_in} <= 4'hf;
		go(8);
		cmp("wide", 29'h1fffffff, data_out);
		cmp("mode", 4'he, {parallel_clock_oe_out, ctrl_local_out, ctrl_bypass_out, autostart_select_out});
		cmp("flags", 4'hf, {data_oe_out, audio_oe_out, bus_wide_out, clock_falling_edge_out});
		@(posedge clock_in) ctrl_direction_select_in <= 0;
		equalizer_boost_select_in <= 1;
		go(8);
		cmp("auto", 7'h49, {equalizer_tuning_code_out, ctrl_local_out, ctrl_bypass_out, autostart_select_out});
		b = n;
		repeat (3) begin
			@(posedge clock_in) irq_in <= !irq_in;
			go(6);
		end
		cmp("irq", 3, n - b);
		@(posedge clock_in) power_down_n_in <= 0;
		{general_pin_zero_drive_low_in, general_pin_one_drive_low_in} <= 2'h3;
		go(9);
		cmp("pd", 0, {general_pin_zero_oe_out, general_pin_one_oe_out});
		@(posedge clock_in) power_down_n_in <= 1;
		go(10);
		cmp("up", 6'h13, {equalizer_tuning_code_out, general_pin_zero_oe_out, general_pin_one_oe_out});
		cmp("pin_lvl", 0, {general_pin_zero_out, general_pin_one_out});
		@(posedge clock_in) out_enable_n_in <= 1;
		go(8);
		cmp("off", 0, {data_oe_out, audio_oe_out, parallel_clock_oe_out});
		wrap_up;
	end
endmodule // tb
bind dsc_strap_config dsc_props i_props(.clock_in(clock_in), .rst_in(rst_in), .out_enable_n_in(out_enable_n_in),
	.data_oe_out(data_oe_out), .irq_in(irq_in), .irq_toggle_out(irq_toggle_out), .power_down_n_in(power_down_n_in),
	.general_pin_one_oe_out(general_pin_one_oe_out), .bus_width_select_in(bus_width_select_in),
	.bus_wide_out(bus_wide_out), .equalizer_boost_select_in(equalizer_boost_select_in),
	.equalizer_tuning_code_out(equalizer_tuning_code_out));
